// ===== design/bgc_pkg.sv
// Package for the bridge gate control and short protection block.
// Assumes a 20 MHz system clock; shared by all design files.
package bgc_pkg;
    localparam int REF_CLK_MHZ = 20;
    // Short detection delays in nanoseconds, indexed by delay code
    localparam int DLY_00_NS = 3200;
    localparam int DLY_01_NS = 1600;
    localparam int DLY_10_NS = 1200;
    localparam int DLY_11_NS = 800;
    localparam int DLY_00_CYC = (DLY_00_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int DLY_01_CYC = (DLY_01_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int DLY_10_CYC = (DLY_10_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int DLY_11_CYC = (DLY_11_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int DLY_W = 7;
    // Short retries before latching a bridge off
    localparam logic [1:0] SHORT_RETRIES = 2'h3;
    // Gate drive strength steps
    localparam logic [2:0] DRIVE_MIN = 3'h1;
    localparam logic [2:0] DRIVE_MAX = 3'h7;
    localparam logic [3:0] OFF_TIME_ZERO = 4'h0;

    // Half-bridge commands from the chopper side
    typedef struct packed {
        logic high_on;
        logic low_on;
    } bgc_leg_cmd_t;

    // Detector inputs for one coil
    typedef struct packed {
        logic high_side_hit;
        logic high_side_hit_sens;
        logic low_side_hit;
    } bgc_det_t;

    // Fault flags for one coil
    typedef struct packed {
        logic fault;
        logic low_side_fault;
        logic high_side_fault;
    } bgc_flags_t;

    typedef enum logic [2:0] {
        LEG_OFF = 3'b001,
        LEG_HIGH = 3'b010,
        LEG_LOW = 3'b100
    } bgc_leg_state_t;
endpackage

// ===== design/bgc_half_bridge.sv
// One half-bridge with the cross-conduction guard.
// Assumes gate discharged indications are synchronous to the clock.
`timescale 1ns/1ps
module bgc_half_bridge (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic enable_i,
    input bgc_pkg::bgc_leg_cmd_t cmd_i,
    input wire logic high_gate_off_i,
    input wire logic low_gate_off_i,
    output logic high_on_o,
    output logic low_on_o
);
    bgc_pkg::bgc_leg_state_t state_reg;
    bgc_pkg::bgc_leg_state_t state_next;
    wire want_high = enable_i && cmd_i.high_on && !cmd_i.low_on;
    wire want_low = enable_i && cmd_i.low_on && !cmd_i.high_on;

    // Turn-on waits until the opposite gate reads discharged
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bgc_pkg::LEG_OFF: begin
                if (want_high && low_gate_off_i) begin
                    state_next = bgc_pkg::LEG_HIGH;
                end else if (want_low && high_gate_off_i) begin
                    state_next = bgc_pkg::LEG_LOW;
                end
            end
            bgc_pkg::LEG_HIGH: if (!want_high) state_next = bgc_pkg::LEG_OFF;
            bgc_pkg::LEG_LOW: if (!want_low) state_next = bgc_pkg::LEG_OFF;
            default: state_next = bgc_pkg::LEG_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= bgc_pkg::LEG_OFF;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign high_on_o = (state_reg == bgc_pkg::LEG_HIGH);
    assign low_on_o = (state_reg == bgc_pkg::LEG_LOW);

    a_guard_high_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && $rose(high_on_o) |-> $past(low_gate_off_i))
        else $error("high side turned on before low gate discharged");
    a_guard_low_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && $rose(low_on_o) |-> $past(high_gate_off_i))
        else $error("low side turned on before high gate discharged");
endmodule // bgc_half_bridge

// ===== design/bgc_short_guard.sv
// Short detection delay, retry counting and latch-off for one bridge.
// Assumes detector hits are synchronous and chop_start_i pulses once per chopper cycle.
`timescale 1ns/1ps
module bgc_short_guard (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic drv_disabled_i,
    input wire logic chop_start_i,
    input wire logic [1:0] delay_code_i,
    input wire logic hs_sens_i,
    input wire logic hs_disable_i,
    input wire logic ls_enable_i,
    input bgc_pkg::bgc_det_t det_i,
    output logic trip_o,
    output logic latched_o,
    output bgc_pkg::bgc_flags_t flags_o
);
    logic [bgc_pkg::DLY_W-1:0] hs_cnt_reg;
    logic [bgc_pkg::DLY_W-1:0] ls_cnt_reg;
    logic [1:0] retry_reg;
    logic trip_reg;
    logic latched_reg;
    bgc_pkg::bgc_flags_t flags_reg;

    function automatic logic [bgc_pkg::DLY_W-1:0] delay_cycles(input logic [1:0] code);
        case (code)
            2'h0: delay_cycles = bgc_pkg::DLY_W'(bgc_pkg::DLY_00_CYC);
            2'h1: delay_cycles = bgc_pkg::DLY_W'(bgc_pkg::DLY_01_CYC);
            2'h2: delay_cycles = bgc_pkg::DLY_W'(bgc_pkg::DLY_10_CYC);
            default: delay_cycles = bgc_pkg::DLY_W'(bgc_pkg::DLY_11_CYC);
        endcase
    endfunction

    wire [bgc_pkg::DLY_W-1:0] limit = delay_cycles(delay_code_i);
    wire hs_raw = hs_sens_i ? det_i.high_side_hit_sens : det_i.high_side_hit;
    wire hs_act = hs_raw && !hs_disable_i && !latched_reg;
    wire ls_act = det_i.low_side_hit && ls_enable_i && !latched_reg;
    wire hs_conf = hs_act && (hs_cnt_reg == limit - 1'b1);
    wire ls_conf = ls_act && (ls_cnt_reg == limit - 1'b1);
    wire confirm = (hs_conf || ls_conf) && !trip_reg;
    wire last_try = (retry_reg == bgc_pkg::SHORT_RETRIES);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_cnt_reg <= '0;
            ls_cnt_reg <= '0;
            retry_reg <= 2'h0;
            trip_reg <= 1'b0;
            latched_reg <= 1'b0;
            flags_reg <= '0;
        end else if (ce_i) begin
            if (drv_disabled_i) begin
                hs_cnt_reg <= '0;
                ls_cnt_reg <= '0;
                retry_reg <= 2'h0;
                trip_reg <= 1'b0;
                latched_reg <= 1'b0;
                flags_reg <= '0;
            end else begin
                hs_cnt_reg <= hs_act ? hs_cnt_reg + 1'b1 : '0;
                ls_cnt_reg <= ls_act ? ls_cnt_reg + 1'b1 : '0;
                if (confirm) begin
                    trip_reg <= 1'b1;
                    if (last_try) begin
                        latched_reg <= 1'b1;
                        flags_reg.fault <= 1'b1;
                    end else begin
                        retry_reg <= retry_reg + 2'h1;
                    end
                    if (hs_conf) flags_reg.high_side_fault <= 1'b1;
                    if (ls_conf) flags_reg.low_side_fault <= 1'b1;
                end else if (chop_start_i) begin
                    trip_reg <= 1'b0; // Retry on next chopper cycle
                end
            end
        end
    end

    assign trip_o = trip_reg || latched_reg;
    assign latched_o = latched_reg;
    assign flags_o = flags_reg;

    a_latch_after_retries: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !drv_disabled_i && confirm && last_try |=> latched_o)
        else $error("bridge not latched off after retries");
    a_no_latch_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !drv_disabled_i && confirm && !last_try && !latched_o |=> !latched_o)
        else $error("bridge latched before retries used");
    a_flags_clear_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && drv_disabled_i |=> flags_o == '0 && !latched_o)
        else $error("flags not cleared while driver disabled");
    a_ls_needs_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !ls_enable_i |=> !$rose(flags_o.low_side_fault))
        else $error("low side fault without enable");
    a_hs_disable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && hs_disable_i |=> !$rose(flags_o.high_side_fault))
        else $error("high side fault while protection disabled");
endmodule // bgc_short_guard

// ===== design/bgc_top.sv
// Gate control top: slope codes, bridge enables and short protection for coils A and B.
// Assumes all inputs synchronous to REF_CLK_I; gate feedback comes from comparators.
// Summary of operation
// - Low-side gate drive uses a 3-bit code with shared top bit; 000 and 001 are minimum.
// - High-side gate drive uses a 3-bit code; 001..110 are temperature compensated steps.
// - Compensated high-side codes step up by one when the temperature warning is set.
// - A transistor turns on only after its opposite gate reads discharged.
// - The hardware disable input switches off every bridge transistor.
// - A zero off-time setting disables the bridges like the hardware input.
// - Three retries follow a short before the bridge is latched off.
// - The short detect delay code picks 3.2, 1.6, 1.2 or 0.8 microseconds.
// - A sensitivity bit selects low or high high-side detector sensitivity.
// - A disable bit set to one turns off high-side short protection.
// - Low-side detection runs only while its enable bit is one.
// - Each coil has a fault flag for a short persisting over chopper cycles.
// - All fault flags clear whenever the transistors are disabled.
// - Low-side and high-side confirmed shorts are reported in separate per-coil flags.
// - A confirmed short turns off only the affected bridge and sets its flag.
`timescale 1ns/1ps
module bgc_top (
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic CLK_EN_I,
    input wire logic DRIVER_OFF_INPUT_I,
    input wire logic [3:0] OFF_TIME_SETTING_I,
    input wire logic SLOPE_SHARED_MSB_I,
    input wire logic [1:0] LOW_SIDE_SLOPE_CODE_I,
    input wire logic [1:0] HIGH_SIDE_SLOPE_CODE_I,
    input wire logic TEMP_WARNING_I,
    input wire logic [1:0] SHORT_DETECT_DELAY_CODE_I,
    input wire logic HIGH_SIDE_DETECTOR_SENSITIVITY_I,
    input wire logic SHORT_PROTECT_DISABLE_I,
    input wire logic LOW_SIDE_OVERCURRENT_ENABLE_I,
    input wire logic CHOP_START_A_I,
    input wire logic CHOP_START_B_I,
    input bgc_pkg::bgc_leg_cmd_t [3:0] LEG_CMD_I,
    input wire logic [3:0] HIGH_GATE_OFF_I,
    input wire logic [3:0] LOW_GATE_OFF_I,
    input bgc_pkg::bgc_det_t DET_A_I,
    input bgc_pkg::bgc_det_t DET_B_I,
    output logic [3:0] HIGH_GATE_ON_O,
    output logic [3:0] LOW_GATE_ON_O,
    output logic [2:0] LOW_SIDE_DRIVE_O,
    output logic [2:0] HIGH_SIDE_DRIVE_O,
    output logic COIL_A_FAULT_FLAG_O,
    output logic COIL_B_FAULT_FLAG_O,
    output logic COIL_A_LOW_SIDE_FAULT_O,
    output logic COIL_B_LOW_SIDE_FAULT_O,
    output logic COIL_A_HIGH_SIDE_FAULT_O,
    output logic COIL_B_HIGH_SIDE_FAULT_O
);
    logic [3:0] high_on_reg;
    logic [3:0] low_on_reg;
    logic [2:0] ls_drive_reg;
    logic [2:0] hs_drive_reg;
    bgc_pkg::bgc_flags_t flags_a_reg;
    bgc_pkg::bgc_flags_t flags_b_reg;
    logic [3:0] leg_high;
    logic [3:0] leg_low;
    logic trip_a;
    logic trip_b;
    bgc_pkg::bgc_flags_t flags_a;
    bgc_pkg::bgc_flags_t flags_b;

    // Driver disabled by pin or by zero off-time
    wire drv_disabled = DRIVER_OFF_INPUT_I
        || (OFF_TIME_SETTING_I == bgc_pkg::OFF_TIME_ZERO);

    // Slope decode; the top bit is common to both codes
    wire [2:0] ls_code = {SLOPE_SHARED_MSB_I, LOW_SIDE_SLOPE_CODE_I};
    wire [2:0] hs_code = {SLOPE_SHARED_MSB_I, HIGH_SIDE_SLOPE_CODE_I};
    wire [2:0] ls_drive = (ls_code == 3'h0) ? bgc_pkg::DRIVE_MIN : ls_code;
    wire hs_comp = (hs_code != 3'h0) && (hs_code != bgc_pkg::DRIVE_MAX);
    wire [2:0] hs_base = (hs_code == 3'h0) ? bgc_pkg::DRIVE_MIN : hs_code;
    wire [2:0] hs_drive = (hs_comp && TEMP_WARNING_I) ? hs_base + 3'h1 : hs_base;

    // Bridge A uses legs 0 and 1, bridge B legs 2 and 3
    wire [3:0] leg_enable = {{2{!drv_disabled && !trip_b}},
        {2{!drv_disabled && !trip_a}}};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_leg
            bgc_half_bridge u_leg (
                .clk_i(REF_CLK_I),
                .rst_n_i(RESETN_I),
                .ce_i(CLK_EN_I),
                .enable_i(leg_enable[g]),
                .cmd_i(LEG_CMD_I[g]),
                .high_gate_off_i(HIGH_GATE_OFF_I[g]),
                .low_gate_off_i(LOW_GATE_OFF_I[g]),
                .high_on_o(leg_high[g]),
                .low_on_o(leg_low[g])
            );
        end
    endgenerate

    bgc_short_guard u_guard_a (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .ce_i(CLK_EN_I),
        .drv_disabled_i(drv_disabled),
        .chop_start_i(CHOP_START_A_I),
        .delay_code_i(SHORT_DETECT_DELAY_CODE_I),
        .hs_sens_i(HIGH_SIDE_DETECTOR_SENSITIVITY_I),
        .hs_disable_i(SHORT_PROTECT_DISABLE_I),
        .ls_enable_i(LOW_SIDE_OVERCURRENT_ENABLE_I),
        .det_i(DET_A_I),
        .trip_o(trip_a),
        .latched_o(),
        .flags_o(flags_a)
    );

    bgc_short_guard u_guard_b (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .ce_i(CLK_EN_I),
        .drv_disabled_i(drv_disabled),
        .chop_start_i(CHOP_START_B_I),
        .delay_code_i(SHORT_DETECT_DELAY_CODE_I),
        .hs_sens_i(HIGH_SIDE_DETECTOR_SENSITIVITY_I),
        .hs_disable_i(SHORT_PROTECT_DISABLE_I),
        .ls_enable_i(LOW_SIDE_OVERCURRENT_ENABLE_I),
        .det_i(DET_B_I),
        .trip_o(trip_b),
        .latched_o(),
        .flags_o(flags_b)
    );

    // Gate outputs also masked directly so a disable or trip acts in one cycle
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            high_on_reg <= 4'h0;
            low_on_reg <= 4'h0;
            ls_drive_reg <= bgc_pkg::DRIVE_MIN;
            hs_drive_reg <= bgc_pkg::DRIVE_MIN;
            flags_a_reg <= '0;
            flags_b_reg <= '0;
        end else if (CLK_EN_I) begin
            high_on_reg <= leg_high & leg_enable;
            low_on_reg <= leg_low & leg_enable;
            ls_drive_reg <= ls_drive;
            hs_drive_reg <= hs_drive;
            flags_a_reg <= flags_a;
            flags_b_reg <= flags_b;
        end
    end

    assign HIGH_GATE_ON_O = high_on_reg;
    assign LOW_GATE_ON_O = low_on_reg;
    assign LOW_SIDE_DRIVE_O = ls_drive_reg;
    assign HIGH_SIDE_DRIVE_O = hs_drive_reg;
    assign COIL_A_FAULT_FLAG_O = flags_a_reg.fault;
    assign COIL_B_FAULT_FLAG_O = flags_b_reg.fault;
    assign COIL_A_LOW_SIDE_FAULT_O = flags_a_reg.low_side_fault;
    assign COIL_B_LOW_SIDE_FAULT_O = flags_b_reg.low_side_fault;
    assign COIL_A_HIGH_SIDE_FAULT_O = flags_a_reg.high_side_fault;
    assign COIL_B_HIGH_SIDE_FAULT_O = flags_b_reg.high_side_fault;

    a_disable_all_off: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && drv_disabled |=> HIGH_GATE_ON_O == 4'h0 && LOW_GATE_ON_O == 4'h0)
        else $error("gates on while driver disabled");
    a_zero_off_time: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && OFF_TIME_SETTING_I == bgc_pkg::OFF_TIME_ZERO |=> HIGH_GATE_ON_O == 4'h0
        && LOW_GATE_ON_O == 4'h0)
        else $error("gates on with zero off time");
    a_ls_slope_min: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && ls_code <= 3'h1 |=> LOW_SIDE_DRIVE_O == 3'h1)
        else $error("low side minimum drive wrong");
    a_hs_slope_max: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && hs_code == 3'h7 |=> HIGH_SIDE_DRIVE_O == 3'h7)
        else $error("high side max drive wrong");
    a_hs_slope_min: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && hs_code == 3'h0 |=> HIGH_SIDE_DRIVE_O == 3'h1)
        else $error("high side minimum drive wrong");
    a_hs_temp_step: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && hs_code == 3'h3 && TEMP_WARNING_I |=> HIGH_SIDE_DRIVE_O == 3'h4)
        else $error("temperature step missing");
    a_hs_no_temp: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && hs_code == 3'h3 && !TEMP_WARNING_I |=> HIGH_SIDE_DRIVE_O == 3'h3)
        else $error("step raised without temperature warning");
    a_bridge_a_only: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && trip_a && !trip_b |=> HIGH_GATE_ON_O[1:0] == 2'h0
        && LOW_GATE_ON_O[1:0] == 2'h0)
        else $error("bridge A on while tripped");
    a_bridge_b_only: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && trip_b && !trip_a |=> HIGH_GATE_ON_O[3:2] == 2'h0
        && LOW_GATE_ON_O[3:2] == 2'h0)
        else $error("bridge B on while tripped");
    a_flags_clear_top: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        CLK_EN_I && drv_disabled ##1 CLK_EN_I |=> flags_a_reg == '0 && flags_b_reg == '0)
        else $error("coil flags not cleared while driver disabled");
    a_fault_a_off: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        COIL_A_FAULT_FLAG_O |-> HIGH_GATE_ON_O[1:0] == 2'h0 && LOW_GATE_ON_O[1:0] == 2'h0)
        else $error("bridge A on after latched fault");
    a_fault_b_off: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        COIL_B_FAULT_FLAG_O |-> HIGH_GATE_ON_O[3:2] == 2'h0 && LOW_GATE_ON_O[3:2] == 2'h0)
        else $error("bridge B on after latched fault");
endmodule // bgc_top

// ===== sim/bgc_mosfet_model.sv
// Behavioural power stage: gate discharge feedback for four half-bridges.
// Assumes gate on commands come registered from the gate control block.
`timescale 1ns/1ps
module bgc_mosfet_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic [3:0] high_on_i,
    input wire logic [3:0] low_on_i,
    output logic [3:0] high_off_o,
    output logic [3:0] low_off_o
);
    logic [3:0] hcnt_reg [4];
    logic [3:0] lcnt_reg [4];
    logic [3:0] lim;
    // Slow gates take a dozen cycles to discharge
    assign lim = slow_i ? 4'hc : 4'h1;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        for (int k = 0; k < 4; k++) begin
            if (!rst_n_i) begin
                hcnt_reg[k] <= 4'hf;
                lcnt_reg[k] <= 4'hf;
            end else begin
                hcnt_reg[k] <= high_on_i[k] ? 4'h0 : hcnt_reg[k] + 4'(hcnt_reg[k] != 4'hf);
                lcnt_reg[k] <= low_on_i[k] ? 4'h0 : lcnt_reg[k] + 4'(lcnt_reg[k] != 4'hf);
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            high_off_o[k] = !high_on_i[k] && (hcnt_reg[k] >= lim);
            low_off_o[k] = !low_on_i[k] && (lcnt_reg[k] >= lim);
        end
    end
endmodule // bgc_mosfet_model

// ===== sim/bgc_top_test.sv
// Self-checking bench for the gate control block with a power stage model.
// Assumes a 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`define CHK(act, exp) begin \
    num_checks++; \
    if ((act) !== (exp)) begin \
        mismatches++; \
        $display("BAD t=%0t act=%0h exp=%0h", $time, act, exp); \
    end \
end
module bgc_top_test;
    typedef struct packed { logic [3:0] kind; logic [7:0] val; } bgc_note_t;
    logic clk = 1'b0;
    logic ce = 1'b1;
    logic rst_n = 1'b0;
    logic drv_off, msb, temp, sens, dis, lsen, chop_a, chop_b, slow;
    logic [3:0] off_time, hi_off, lo_off, hi_on, lo_on;
    logic [1:0] lcode, hcode, dly;
    logic [2:0] ldrv, hdrv, lc, hc;
    logic fa, fb, la, lb, ha, hb;
    bgc_pkg::bgc_leg_cmd_t [3:0] cmd;
    bgc_pkg::bgc_det_t det_a, det_b;
    bgc_note_t notes[$];
    bgc_note_t nt;
    event look;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    int dly_cyc[4] = '{bgc_pkg::DLY_00_CYC, bgc_pkg::DLY_01_CYC, bgc_pkg::DLY_10_CYC,
                       bgc_pkg::DLY_11_CYC};
    logic [2:0] dets[5] = '{3'h2, 3'h2, 3'h4, 3'h1, 3'h1};
    logic [2:0] cfgs[5] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1};
    logic [2:0] exps[5] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h2};

    always #25 clk = ~clk;

    bgc_top u_bgc_top (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(ce), .DRIVER_OFF_INPUT_I(drv_off),
        .OFF_TIME_SETTING_I(off_time), .SLOPE_SHARED_MSB_I(msb),
        .LOW_SIDE_SLOPE_CODE_I(lcode), .HIGH_SIDE_SLOPE_CODE_I(hcode), .TEMP_WARNING_I(temp),
        .SHORT_DETECT_DELAY_CODE_I(dly), .HIGH_SIDE_DETECTOR_SENSITIVITY_I(sens),
        .SHORT_PROTECT_DISABLE_I(dis), .LOW_SIDE_OVERCURRENT_ENABLE_I(lsen),
        .CHOP_START_A_I(chop_a), .CHOP_START_B_I(chop_b), .LEG_CMD_I(cmd),
        .HIGH_GATE_OFF_I(hi_off), .LOW_GATE_OFF_I(lo_off), .DET_A_I(det_a), .DET_B_I(det_b),
        .HIGH_GATE_ON_O(hi_on), .LOW_GATE_ON_O(lo_on), .LOW_SIDE_DRIVE_O(ldrv),
        .HIGH_SIDE_DRIVE_O(hdrv), .COIL_A_FAULT_FLAG_O(fa), .COIL_B_FAULT_FLAG_O(fb),
        .COIL_A_LOW_SIDE_FAULT_O(la), .COIL_B_LOW_SIDE_FAULT_O(lb),
        .COIL_A_HIGH_SIDE_FAULT_O(ha), .COIL_B_HIGH_SIDE_FAULT_O(hb)
    );

    bgc_mosfet_model u_bgc_mosfet_model (
        .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .high_on_i(hi_on), .low_on_i(lo_on),
        .high_off_o(hi_off), .low_off_o(lo_off)
    );

    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int cyc);
        repeat (cyc) @(negedge clk);
    endtask

    task automatic note(input logic [3:0] k, input logic [7:0] v);
        notes.push_back('{k, v});
        -> look;
    endtask

    task automatic wait_high(output int cnt);
        cnt = 0;
        while (hi_on !== 4'hf && cnt < 60) begin
            tick(1);
            cnt++;
        end
        if (cnt >= 60) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic pulse(input logic b, input logic [2:0] d, input int cyc);
        if (b) det_b = bgc_pkg::bgc_det_t'(d);
        else det_a = bgc_pkg::bgc_det_t'(d);
        tick(cyc);
        det_a = '0;
        det_b = '0;
        tick(3);
    endtask

    // Driver disable and re-enable: clears a latched shutdown without a reset
    task automatic recycle();
        drv_off = 1'b1;
        tick(2);
        note(4'h4, 8'h0);
        note(4'h5, 8'h0);
        drv_off = 1'b0;
        wait_high(n);
    endtask

    // Result watcher: takes every queued note, oldest first, and compares each with the outputs
    initial forever begin
        @(look);
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            case (nt.kind)
                4'h0: `CHK(ldrv, nt.val[2:0])
                4'h1: `CHK(hdrv, nt.val[2:0])
                4'h2: `CHK(hi_on, nt.val[3:0])
                4'h3: `CHK(lo_on, nt.val[3:0])
                4'h4: `CHK({fa, la, ha}, nt.val[2:0])
                default: `CHK({fb, lb, hb}, nt.val[2:0])
            endcase
        end
    end

    initial begin
        {drv_off, msb, temp, sens, dis, lsen, chop_a, chop_b, lcode, hcode, dly} = '0;
        {det_a, det_b, cmd} = '0;
        off_time = 4'h4;
        slow = 1'b1;
        n = $urandom(32'h11d253a6);
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            {msb, lcode, temp} = {i[2:0], i[3]};
            hcode = 2'($urandom);
            tick(2);
            lc = {msb, lcode};
            hc = {msb, hcode};
            note(4'h0, (lc < 3'h2) ? 8'h1 : 8'(lc));
            note(4'h1, (hc == 3'h0) ? 8'h1 : (hc == 3'h7) ? 8'h7 : 8'(hc) + 8'(temp));
        end
        cmd = {4{2'b01}};
        tick(3);
        note(4'h3, 8'h0f);
        cmd[3] = 2'b11;
        tick(3);
        note(4'h3, 8'h07);
        cmd = {4{2'b10}};
        wait_high(n);
        `CHK(n >= 12, 1'b1)
        note(4'h3, 8'h00);
        slow = 1'b0;
        for (int j = 0; j < 2; j++) begin
            if (j == 0) drv_off = 1'b1;
            else off_time = bgc_pkg::OFF_TIME_ZERO;
            tick(2);
            note(4'h2, 8'h0);
            note(4'h3, 8'h0);
            {drv_off, off_time} = 5'h04;
            wait_high(n);
        end
        // Clock enable low freezes the gates even against a disable
        ce = 1'b0;
        drv_off = 1'b1;
        tick(3);
        note(4'h2, 8'h0f);
        ce = 1'b1;
        tick(2);
        note(4'h2, 8'h00);
        drv_off = 1'b0;
        wait_high(n);
        lsen = 1'b1;
        for (int c = 0; c < 4; c++) begin
            dly = 2'(c);
            pulse(1'b0, c[0] ? 3'h1 : 3'h4, dly_cyc[c] - 1);
            note(4'h4, 8'h0);
            pulse(1'b0, c[0] ? 3'h1 : 3'h4, dly_cyc[c]);
            note(4'h2, 8'h0c);
            note(4'h4, c[0] ? 8'h02 : 8'h01);
            recycle();
        end
        for (int r = 0; r < 4; r++) begin
            det_b = bgc_pkg::bgc_det_t'(3'h4);
            pulse(1'b0, 3'h4, 20);
            note(4'h4, (r < 3) ? 8'h1 : 8'h5);
            note(4'h5, (r < 3) ? 8'h1 : 8'h5);
            {chop_a, chop_b} = 2'b11;
            tick(1);
            {chop_a, chop_b} = 2'b00;
            tick(4);
            note(4'h2, (r < 3) ? 8'h0f : 8'h00);
        end
        note(4'h5, 8'h05);
        recycle();
        for (int t = 0; t < 5; t++) begin
            {sens, dis, lsen} = cfgs[t];
            pulse(1'b1, dets[t], 20);
            note(4'h5, {5'h0, exps[t]});
            note(4'h2, (exps[t] != 3'h0) ? 8'h03 : 8'h0f);
            recycle();
        end
        // Reset in mid-run: gates off, drive back to minimum, then normal start
        rst_n = 1'b0;
        tick(2);
        note(4'h2, 8'h00);
        note(4'h0, 8'h01);
        rst_n = 1'b1;
        wait_high(n);
        note(4'h0, 8'h07);
        tick(4);
        end_of_test();
    end
endmodule // bgc_top_test
